/* hw/slpr_decode.sv */
`timescale 1ns/100ps
module slpr_decode
	import slpr_pkg::*;
(
	input wire logic [4:0] lane_m1,
	input wire logic [7:0] oct_m1,
	input wire logic [4:0] k_m1,
	input wire logic [7:0] conv_m1,
	input wire logic [4:0] s_m1,
	output logic [3:0] lanes,
	output logic [2:0] octets,
	output logic [5:0] frames,
	output logic [2:0] convs,
	output logic [1:0] samples
);

	// ------------------------------------------------------------
	// Minus-one fields to counts
	// ------------------------------------------------------------
	// Stored fields are already limited to legal codes, so narrow sums suffice
	always_comb begin
		lanes = 4'(lane_m1) + 4'h1;
		octets = 3'(oct_m1) + 3'h1;
		frames = 6'(k_m1) + 6'h01;
		convs = 3'(conv_m1) + 3'h1;
		samples = 2'(s_m1) + 2'h1;
	end

endmodule

/* hw/slpr_pkg.sv */
package slpr_pkg;

	// ------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam logic [11:0] OFS_LANE = 12'h453;
	localparam logic [11:0] OFS_OCT = 12'h454;
	localparam logic [11:0] OFS_KFR = 12'h455;
	localparam logic [11:0] OFS_CONV = 12'h456;
	localparam logic [11:0] OFS_CSRES = 12'h457;
	localparam logic [11:0] OFS_SCNP = 12'h458;
	localparam logic [11:0] OFS_VERS = 12'h459;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SCR_BIT = 7;
	localparam int LO5_HI = 4;
	localparam int TOP3_LO = 5;
	localparam int CS_LO = 6;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic RST_SCR = 1'b1;
	localparam logic [4:0] RST_LANE_M1 = 5'h03;
	localparam logic [7:0] RST_OCT_M1 = 8'h00;
	localparam logic [4:0] RST_K_M1 = 5'h1F;
	localparam logic [7:0] RST_CONV_M1 = 8'h01;
	localparam logic [1:0] RST_CS = 2'h0;
	localparam logic [4:0] RST_RES_M1 = 5'h0F;
	localparam logic [2:0] RST_SUBCLASS = 3'h1;
	localparam logic [4:0] RST_NP_M1 = 5'h0F;
	localparam logic [2:0] RST_VERSION = 3'h1;
	localparam logic [4:0] RST_S_M1 = 5'h00;
	localparam logic [3:0] RST_LANES = 4'h4;
	localparam logic [2:0] RST_OCTETS = 3'h1;
	localparam logic [5:0] RST_FRAMES = 6'h20;
	localparam logic [2:0] RST_CONVS = 3'h2;
	localparam logic [1:0] RST_SAMPLES = 2'h1;
	localparam logic RST_SUB_SEL = 1'b1;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [7:0] ENC_ONE = 8'h00;
	localparam logic [7:0] ENC_TWO = 8'h01;
	localparam logic [7:0] ENC_FOUR = 8'h03;
	localparam logic [7:0] ENC_EIGHT = 8'h07;
	localparam logic [4:0] K_SIXTEEN = 5'h0F;
	localparam logic [4:0] K_THIRTY_TWO = 5'h1F;
	localparam logic [2:0] SUBCLASS_ZERO = 3'h0;
	localparam logic [2:0] SUBCLASS_ONE = 3'h1;

	// One, two or four
	function automatic logic slpr_enc_124(input logic [7:0] v);
		return (v == ENC_ONE) || (v == ENC_TWO) || (v == ENC_FOUR);
	endfunction

	// One or two
	function automatic logic slpr_enc_12(input logic [7:0] v);
		return (v == ENC_ONE) || (v == ENC_TWO);
	endfunction

endpackage

/* hw/slpr_regs.sv */
`timescale 1ns/100ps
// Contract
// - A five-bit lanes-minus-one field resets to 3 in the lane-setting register at 0x453.
// - Lane codes 0,1,3,7 mean 1,2,4,8 lanes and code 7 is taken only on a single link.
// - The octets-per-frame field resets to 0 and holds only codes 0, 1 or 3.
// - Frames per multiframe holds only 0x0F or 0x1F, resets to 0x1F, upper bits read 0.
// - Converter codes 0,1,3 mean 1,2,4 converters, 3 only on a single link, reset is 1.
// - The subclass field takes 0 or 1 and resets to subclass one.
// - The samples-per-frame field resets to 0 and holds only codes 0 or 1.
module slpr_regs
	import slpr_pkg::*;
#(
	parameter int ADDR_WIDTH = ADDR_W
)(
	input wire logic clock,
	input wire logic reset,
	input wire logic [ADDR_WIDTH-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic single_link,
	input wire logic octet_valid,
	output logic descramble_en,
	output logic [3:0] lane_count,
	output logic [2:0] frame_octets,
	output logic [5:0] multiframe_frames,
	output logic [2:0] converter_count,
	output logic [1:0] frame_samples,
	output logic subclass_select,
	output logic [2:0] link_standard_version,
	output logic [1:0] octet_index,
	output logic [4:0] frame_index,
	output logic frame_end,
	output logic multiframe_end
);

	generate
		if (ADDR_WIDTH < 12) begin : g_bad_addr
			$error("ADDR_WIDTH must cover the 12-bit register map");
		end
	endgenerate

	// ------------------------------------------------------------
	// Register fields
	// ------------------------------------------------------------
	logic scr_q, scr_d;
	logic [4:0] lane_m1_q, lane_m1_d;
	logic [7:0] oct_m1_q, oct_m1_d;
	logic [4:0] k_m1_q, k_m1_d;
	logic [7:0] conv_m1_q, conv_m1_d;
	logic [1:0] cs_q, cs_d;
	logic [4:0] res_m1_q, res_m1_d;
	logic [2:0] subcl_q, subcl_d;
	logic [4:0] np_m1_q, np_m1_d;
	logic [2:0] ver_q, ver_d;
	logic [4:0] s_m1_q, s_m1_d;
	logic [7:0] rdata_d;
	logic [11:0] addr;

	assign addr = reg_addr[11:0];

	always_comb begin
		scr_d = scr_q;
		lane_m1_d = lane_m1_q;
		oct_m1_d = oct_m1_q;
		k_m1_d = k_m1_q;
		conv_m1_d = conv_m1_q;
		cs_d = cs_q;
		res_m1_d = res_m1_q;
		subcl_d = subcl_q;
		np_m1_d = np_m1_q;
		ver_d = ver_q;
		s_m1_d = s_m1_q;
		if (reg_wr) begin
			case (addr)
				OFS_LANE: begin
					scr_d = reg_wdata[SCR_BIT];
					// Illegal lane codes leave the field as it was
					if (slpr_enc_124({3'h0, reg_wdata[LO5_HI:0]}) ||
					    ({3'h0, reg_wdata[LO5_HI:0]} == ENC_EIGHT && single_link)) begin
						lane_m1_d = reg_wdata[LO5_HI:0];
					end
				end
				OFS_OCT: begin
					if (slpr_enc_124(reg_wdata)) begin
						oct_m1_d = reg_wdata;
					end
				end
				OFS_KFR: begin
					if (reg_wdata[LO5_HI:0] == K_SIXTEEN || reg_wdata[LO5_HI:0] == K_THIRTY_TWO) begin
						k_m1_d = reg_wdata[LO5_HI:0];
					end
				end
				OFS_CONV: begin
					if (slpr_enc_12(reg_wdata) || (reg_wdata == ENC_FOUR && single_link)) begin
						conv_m1_d = reg_wdata;
					end
				end
				OFS_CSRES: begin
					// Stored as written; keeping them legal is software's job
					cs_d = reg_wdata[7:CS_LO];
					res_m1_d = reg_wdata[LO5_HI:0];
				end
				OFS_SCNP: begin
					if (slpr_enc_12({5'h00, reg_wdata[7:TOP3_LO]})) begin
						subcl_d = reg_wdata[7:TOP3_LO];
					end
					np_m1_d = reg_wdata[LO5_HI:0];
				end
				OFS_VERS: begin
					ver_d = reg_wdata[7:TOP3_LO];
					if (slpr_enc_12({3'h0, reg_wdata[LO5_HI:0]})) begin
						s_m1_d = reg_wdata[LO5_HI:0];
					end
				end
				default: begin
				end
			endcase
		end
		case (addr)
			OFS_LANE: rdata_d = {scr_q, 2'h0, lane_m1_q};
			OFS_OCT: rdata_d = oct_m1_q;
			OFS_KFR: rdata_d = {3'h0, k_m1_q};
			OFS_CONV: rdata_d = conv_m1_q;
			OFS_CSRES: rdata_d = {cs_q, 1'b0, res_m1_q};
			OFS_SCNP: rdata_d = {subcl_q, np_m1_q};
			OFS_VERS: rdata_d = {ver_q, s_m1_q};
			default: rdata_d = UNMAPPED_RD;
		endcase
		if (!reg_rd) begin
			rdata_d = reg_rdata;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			scr_q <= RST_SCR;
			lane_m1_q <= RST_LANE_M1;
			oct_m1_q <= RST_OCT_M1;
			k_m1_q <= RST_K_M1;
			conv_m1_q <= RST_CONV_M1;
			cs_q <= RST_CS;
			res_m1_q <= RST_RES_M1;
			subcl_q <= RST_SUBCLASS;
			np_m1_q <= RST_NP_M1;
			ver_q <= RST_VERSION;
			s_m1_q <= RST_S_M1;
			reg_rdata <= UNMAPPED_RD;
			reg_rvalid <= 1'b0;
		end else begin
			scr_q <= scr_d;
			lane_m1_q <= lane_m1_d;
			oct_m1_q <= oct_m1_d;
			k_m1_q <= k_m1_d;
			conv_m1_q <= conv_m1_d;
			cs_q <= cs_d;
			res_m1_q <= res_m1_d;
			subcl_q <= subcl_d;
			np_m1_q <= np_m1_d;
			ver_q <= ver_d;
			s_m1_q <= s_m1_d;
			reg_rdata <= rdata_d;
			reg_rvalid <= reg_rd;
		end
	end

	// ------------------------------------------------------------
	// Decoded link parameters
	// ------------------------------------------------------------
	logic [3:0] lanes_c;
	logic [2:0] octets_c;
	logic [5:0] frames_c;
	logic [2:0] convs_c;
	logic [1:0] samples_c;

	slpr_decode u_decode (
		.lane_m1(lane_m1_q),
		.oct_m1(oct_m1_q),
		.k_m1(k_m1_q),
		.conv_m1(conv_m1_q),
		.s_m1(s_m1_q),
		.lanes(lanes_c),
		.octets(octets_c),
		.frames(frames_c),
		.convs(convs_c),
		.samples(samples_c)
	);

	// ------------------------------------------------------------
	// Frame and multiframe assembly position
	// ------------------------------------------------------------
	// Uses the registered counts, so a new setting takes effect one cycle late
	logic [1:0] oct_idx_d;
	logic [4:0] frm_idx_d;
	logic fend_d, mfend_d;

	always_comb begin
		oct_idx_d = octet_index;
		frm_idx_d = frame_index;
		fend_d = 1'b0;
		mfend_d = 1'b0;
		if (octet_valid) begin
			if (3'(octet_index) + 3'h1 >= frame_octets) begin
				oct_idx_d = 2'h0;
				fend_d = 1'b1;
				if (6'(frame_index) + 6'h01 >= multiframe_frames) begin
					frm_idx_d = 5'h00;
					mfend_d = 1'b1;
				end else begin
					frm_idx_d = frame_index + 5'h01;
				end
			end else begin
				oct_idx_d = octet_index + 2'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			descramble_en <= RST_SCR;
			lane_count <= RST_LANES;
			frame_octets <= RST_OCTETS;
			multiframe_frames <= RST_FRAMES;
			converter_count <= RST_CONVS;
			frame_samples <= RST_SAMPLES;
			subclass_select <= RST_SUB_SEL;
			link_standard_version <= RST_VERSION;
			octet_index <= 2'h0;
			frame_index <= 5'h00;
			frame_end <= 1'b0;
			multiframe_end <= 1'b0;
		end else begin
			descramble_en <= scr_q;
			lane_count <= lanes_c;
			frame_octets <= octets_c;
			multiframe_frames <= frames_c;
			converter_count <= convs_c;
			frame_samples <= samples_c;
			subclass_select <= (subcl_q == SUBCLASS_ONE);
			link_standard_version <= ver_q;
			octet_index <= oct_idx_d;
			frame_index <= frm_idx_d;
			frame_end <= fend_d;
			multiframe_end <= mfend_d;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	lane_reset_a: assert property ($fell(reset) |-> lane_m1_q == 5'h03 && subcl_q == 3'h1 && k_m1_q == 5'h1F)
		else $error("lane, subclass or frame field not at reset value");
	eight_lane_gate_a: assert property (reg_wr && addr == OFS_LANE && reg_wdata[4:0] == 5'h07 && !single_link |=> $stable(lane_m1_q))
		else $error("eight lanes taken without single link");
	eight_lane_take_a: assert property (reg_wr && addr == OFS_LANE && reg_wdata[4:0] == 5'h07 && single_link |=> lane_m1_q == 5'h07 ##1 lane_count == 4'h8)
		else $error("eight-lane setting not applied");
	octet_enc_a: assert property (oct_m1_q == 8'h00 || oct_m1_q == 8'h01 || oct_m1_q == 8'h03)
		else $error("illegal octets-per-frame code stored");
	kfr_read_a: assert property (reg_rd && addr == OFS_KFR |=> reg_rvalid && reg_rdata[7:5] == 3'h0 && (reg_rdata[4:0] == 5'h0F || reg_rdata[4:0] == 5'h1F))
		else $error("frames-per-multiframe readback wrong");
	conv_gate_a: assert property (reg_wr && addr == OFS_CONV && reg_wdata == 8'h03 && !single_link |=> $stable(conv_m1_q))
		else $error("four converters taken without single link");
	samples_enc_a: assert property (s_m1_q <= 5'h01 && subcl_q <= 3'h1)
		else $error("illegal samples or subclass code stored");
	frame_wrap_a: assert property (octet_valid && 3'(octet_index) + 3'h1 == frame_octets |=> frame_end && octet_index == 2'h0)
		else $error("frame end not flagged at last octet");
	mf_end_a: assert property (multiframe_end |-> frame_end && frame_index == 5'h00)
		else $error("multiframe end without frame wrap");

	eight_lane_c: cover property (reg_wr && addr == OFS_LANE && reg_wdata[4:0] == 5'h07 && single_link);
	four_octet_c: cover property (frame_octets == 3'h4 && frame_end);
	mf_sixteen_c: cover property (multiframe_frames == 6'h10 && multiframe_end);
	refused_c: cover property (reg_wr && addr == OFS_OCT && reg_wdata == 8'h02);

endmodule

/* verif/slpr_tx_model.sv */
`timescale 1ns/100ps
module slpr_tx_model (
	input wire logic clock,
	input wire logic reset,
	input wire logic start,
	input wire logic [7:0] count,
	input wire logic gap,
	output logic octet_valid,
	output logic busy
);
	logic [7:0] left_q;
	// ------------------------------------------------------------
	// Lane octet source
	// ------------------------------------------------------------
	// Gap mode idles every other cycle to stretch a frame
	always @(posedge clock) begin
		if (reset) begin
			left_q <= 8'h00;
			octet_valid <= 1'b0;
		end else if (start) begin
			left_q <= count;
			octet_valid <= 1'b0;
		end else if (left_q != 8'h00 && !(gap && octet_valid)) begin
			octet_valid <= 1'b1;
			left_q <= left_q - 8'h01;
		end else begin
			octet_valid <= 1'b0;
		end
	end
	assign busy = (left_q != 8'h00) || octet_valid;
endmodule

/* verif/testbench.sv */
`timescale 1ns/100ps
module testbench;
	import slpr_pkg::*;
	logic clock = 1'b0;
	logic reset, reg_wr, reg_rd, single_link, octet_valid, start, gap, busy;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, count, fe_n, mf_n;
	logic reg_rvalid, descramble_en, subclass_select, frame_end, multiframe_end;
	logic [3:0] lane_count;
	logic [2:0] frame_octets, converter_count, link_standard_version;
	logic [5:0] multiframe_frames;
	logic [1:0] frame_samples, octet_index;
	logic [4:0] frame_index;
	int fail_count = 0;
	int check_count = 0;
	int cyc = 0;
	logic [7:0] rst_tab [7] = '{8'h83, 8'h00, 8'h1F, 8'h01, 8'h0F, 8'h2F, 8'h20};

	always #5 clock = ~clock;

	slpr_regs dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .single_link(single_link), .octet_valid(octet_valid),
		.descramble_en(descramble_en), .lane_count(lane_count), .frame_octets(frame_octets),
		.multiframe_frames(multiframe_frames), .converter_count(converter_count),
		.frame_samples(frame_samples), .subclass_select(subclass_select),
		.link_standard_version(link_standard_version), .octet_index(octet_index),
		.frame_index(frame_index), .frame_end(frame_end), .multiframe_end(multiframe_end));

	slpr_tx_model tx (.clock(clock), .reset(reset), .start(start), .count(count),
		.gap(gap), .octet_valid(octet_valid), .busy(busy));

	// ------------------------------------------------------------
	// Pulse counting and hang guard
	// ------------------------------------------------------------
	always @(posedge clock) begin
		if (reset || start) begin
			fe_n <= 8'h00;
			mf_n <= 8'h00;
		end else begin
			fe_n <= fe_n + 8'(frame_end);
			mf_n <= mf_n + 8'(multiframe_end);
		end
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	// ------------------------------------------------------------
	// Byte port access, driven on the falling edge
	// ------------------------------------------------------------
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		chk("rvalid", 8'h01, {7'h00, reg_rvalid});
		chk("rdata", e, reg_rdata);
	endtask

	// Write, then read back; decoded outputs are settled on return
	task automatic wrd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		rd(a, e);
	endtask

	task automatic reset_check();
		for (int i = 0; i < 7; i++) rd(OFS_LANE + 12'(i), rst_tab[i]);
		chk("lanes", 8'h04, {4'h0, lane_count});
		chk("octets", 8'h01, {5'h00, frame_octets});
		chk("converters", 8'h02, {5'h00, converter_count});
		chk("frames_mf", 8'h20, {2'h0, multiframe_frames});
		chk("samples", 8'h01, {6'h00, frame_samples});
		chk("subclass", 8'h01, {7'h00, subclass_select});
		chk("descramble", 8'h01, {7'h00, descramble_en});
		chk("version", 8'h01, {5'h00, link_standard_version});
		chk("octet_index", 8'h00, {6'h00, octet_index});
		chk("frame_index", 8'h00, {3'h0, frame_index});
	endtask

	task automatic burst(input logic [7:0] n, input logic g, input logic [7:0] fe);
		@(negedge clock);
		count = n;
		gap = g;
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		for (int i = 0; i < 400 && busy; i++) @(negedge clock);
		repeat (3) @(negedge clock);
		chk("frames", fe, fe_n);
		chk("multiframes", 8'h01, mf_n);
		chk("frame_index", 8'h00, {3'h0, frame_index});
		chk("octet_index", 8'h00, {6'h00, octet_index});
	endtask

	initial begin
		reset = 1'b1;
		{reg_wr, reg_rd, single_link, start, gap} = 5'h00;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		count = 8'h00;
		repeat (10) @(posedge clock);
		@(negedge clock);
		reset = 1'b0;
		reset_check();
		rd(12'h45A, UNMAPPED_RD);
		wrd(OFS_LANE, 8'h07, 8'h03);
		chk("descramble", 8'h00, {7'h00, descramble_en});
		single_link = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wrd(OFS_LANE, 8'((1 << i) - 1), 8'((1 << i) - 1));
			chk("lanes", 8'(1 << i), {4'h0, lane_count});
		end
		wrd(OFS_LANE, 8'h82, 8'h87);
		chk("descramble", 8'h01, {7'h00, descramble_en});
		for (int i = 0; i < 3; i++) begin
			wrd(OFS_OCT, 8'((1 << i) - 1), 8'((1 << i) - 1));
			chk("octets", 8'(1 << i), {5'h00, frame_octets});
			wrd(OFS_CONV, 8'((1 << i) - 1), 8'((1 << i) - 1));
			chk("converters", 8'(1 << i), {5'h00, converter_count});
		end
		wrd(OFS_OCT, 8'h02, 8'h03);
		single_link = 1'b0;
		wrd(OFS_CONV, 8'h00, 8'h00);
		wrd(OFS_CONV, 8'h03, 8'h00);
		wrd(OFS_KFR, 8'hEF, 8'h0F);
		chk("frames_mf", 8'h10, {2'h0, multiframe_frames});
		wrd(OFS_KFR, 8'h10, 8'h0F);
		wrd(OFS_CSRES, 8'h0F, 8'h0F);
		wrd(OFS_SCNP, 8'h0F, 8'h0F);
		chk("subclass", 8'h00, {7'h00, subclass_select});
		wrd(OFS_SCNP, 8'h4F, 8'h0F);
		wrd(OFS_SCNP, 8'h2F, 8'h2F);
		chk("subclass", 8'h01, {7'h00, subclass_select});
		wrd(OFS_VERS, 8'h21, 8'h21);
		chk("samples", 8'h02, {6'h00, frame_samples});
		wrd(OFS_VERS, 8'h42, 8'h41);
		chk("version", 8'h02, {5'h00, link_standard_version});
		wrd(OFS_OCT, 8'h01, 8'h01);
		burst(8'd32, 1'b1, 8'd16);
		wrd(OFS_OCT, 8'h03, 8'h03);
		burst(8'd64, 1'b0, 8'd16);
		// Frame count first, so one-octet frames never meet sixteen
		wrd(OFS_KFR, 8'h1F, 8'h1F);
		wrd(OFS_OCT, 8'h00, 8'h00);
		burst(8'd32, 1'b0, 8'd32);
		@(negedge clock);
		reset = 1'b1;
		repeat (3) @(negedge clock);
		reset = 1'b0;
		reset_check();
		results();
	end
endmodule
